// [core/banked_data_memory_status.sv]
// banked data memory, indirect pointers and arithmetic/power status flags
module banked_data_memory_status
   import bdm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic other_reset,
   input wire logic instr_valid,
   input wire op_type instr_op,
   input wire logic [6:0] instr_offset,
   input wire logic [7:0] instr_operand,
   input wire logic [13:0] pm_rdata,
   input wire logic wdt_timeout,
   input wire logic watchdog_kick_instr,
   input wire logic sleep_instr,
   output logic busy,
   output logic done,
   output logic [7:0] result_data,
   output logic [7:0] arith_and_power_flags,
   output logic [7:0] working_accumulator,
   output logic [4:0] bank_select,
   output logic pm_req,
   output logic [14:0] pm_addr
);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   state_type r;
   state_type next_r;

   logic [7:0] gpr_ram [0:GPR_TOTAL-1];
   logic [7:0] common_ram [0:COMMON_BYTES-1];

   logic issue;
   logic finish;
   logic exec;
   logic is_port;
   logic to_pm;
   logic status_target;
   logic [15:0] ptr;
   logic [11:0] addr;
   op_type op;
   logic [7:0] operand;
   logic [7:0] src;
   logic [7:0] res;
   logic [7:0] addend;
   logic cin;
   logic [8:0] sum9;
   logic [4:0] nib;
   logic gpr_we;
   logic com_we;
   logic [GPR_INDEX_W-1:0] gpr_idx;
   logic [3:0] com_idx;
   logic [7:0] wr_data;

   function automatic logic [GPR_INDEX_W-1:0] gpr_index(input logic [11:0] a);
      logic [GPR_INDEX_W-1:0] base;
      base = GPR_INDEX_W'(a[11:7]) * GPR_INDEX_W'(GPR_BYTES);
      return base + GPR_INDEX_W'(a[6:0] - GPR_FIRST);
   endfunction : gpr_index

   // core registers ignore the bank field entirely
   function automatic logic [7:0] read_byte(input logic [11:0] a);
      logic [6:0] off;
      off = a[6:0];
      read_byte = 8'h00;
      if (off < CORE_COUNT)
      begin
         unique case (off)
            OFF_PCL: read_byte = r.pcl;
            OFF_STATUS: read_byte = {3'h0, r.wdt_expiry_n, r.sleep_entered_n, r.zero,
                                     r.nibble_overflow_flag, r.carry};
            OFF_PTR0_LO: read_byte = r.pointer_low[0];
            OFF_PTR0_HI: read_byte = r.pointer_high_byte[0];
            OFF_PTR1_LO: read_byte = r.pointer_low[1];
            OFF_PTR1_HI: read_byte = r.pointer_high_byte[1];
            OFF_BANK: read_byte = {3'h0, r.bank};
            OFF_ACC: read_byte = r.acc;
            OFF_PCLATH: read_byte = r.pclath;
            OFF_INTCON: read_byte = r.intcon;
            default: read_byte = 8'h00;
         endcase
      end
      else if (off >= COMMON_FIRST)
      begin
         read_byte = common_ram[off[3:0]];
      end
      else if (off >= GPR_FIRST)
      begin
         read_byte = gpr_ram[gpr_index(a)];
      end
      // peripheral region is outside this block and reads as zero
   endfunction : read_byte

   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.pm_req = 1'b0;
      gpr_we = 1'b0;
      com_we = 1'b0;
      wr_data = 8'h00;
      // a non power-on reset drops the instruction before it touches any state
      issue = instr_valid && (r.phase == PH_IDLE) && !other_reset;
      finish = (r.phase == PH_PM) && !other_reset;
      // offsets 0 and 1 are the indirect access ports
      is_port = (instr_offset[6:1] == 6'h00);
      ptr = {r.pointer_high_byte[instr_offset[0]], r.pointer_low[instr_offset[0]]};
      to_pm = is_port && ptr[8+PM_SEL_BIT];
      addr = is_port ? ptr[11:0] : {r.bank, instr_offset};
      gpr_idx = gpr_index(addr);
      com_idx = addr[3:0];
      status_target = (addr[6:0] == OFF_STATUS);
      op = finish ? r.op : instr_op;
      operand = finish ? r.operand : instr_operand;
      exec = (issue && !to_pm) || finish;
      src = finish ? pm_rdata[7:0] : read_byte(addr);
      cin = (op == OP_SUB);
      addend = cin ? ~operand : operand;
      sum9 = {1'b0, src} + {1'b0, addend} + {8'h00, cin};
      nib = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
      res = src;
      if (issue && to_pm)
      begin
         // hold the instruction while program memory answers
         next_r.phase = PH_PM;
         next_r.op = instr_op;
         next_r.operand = instr_operand;
         next_r.pm_req = 1'b1;
         next_r.pm_addr = ptr[14:0];
      end
      if (exec)
      begin
         next_r.phase = PH_IDLE;
         next_r.done = 1'b1;
         unique case (op)
            OP_READ:
            begin
               next_r.acc = src;
            end
            OP_WRITE:
            begin
               res = operand;
            end
            OP_ADD, OP_SUB:
            begin
               res = sum9[7:0];
               next_r.zero = (sum9[7:0] == 8'h00);
               next_r.nibble_overflow_flag = nib[4];
               next_r.carry = sum9[8];
            end
            OP_AND:
            begin
               res = src & operand;
               next_r.zero = ((src & operand) == 8'h00);
            end
            OP_RRF:
            begin
               res = {r.carry, src[7:1]};
               next_r.carry = src[0];
            end
            OP_RLF:
            begin
               res = {src[6:0], r.carry};
               next_r.carry = src[7];
            end
            OP_CLR:
            begin
               res = 8'h00;
               next_r.zero = 1'b1;
            end
         endcase
         next_r.result = res;
         // program memory is never written from here
         if (!finish && op != OP_READ)
         begin
            wr_data = res;
            if (addr[6:0] < CORE_COUNT)
            begin
               unique case (addr[6:0])
                  OFF_PCL: next_r.pcl = res;
                  OFF_STATUS:
                  begin
                     // only plain moves reach the flags; others keep their results
                     if (op == OP_WRITE)
                     begin
                        next_r.zero = res[ST_Z];
                        next_r.nibble_overflow_flag = res[ST_DC];
                        next_r.carry = res[ST_C];
                     end
                  end
                  OFF_PTR0_LO: next_r.pointer_low[0] = res;
                  OFF_PTR0_HI: next_r.pointer_high_byte[0] = res;
                  OFF_PTR1_LO: next_r.pointer_low[1] = res;
                  OFF_PTR1_HI: next_r.pointer_high_byte[1] = res;
                  OFF_BANK: next_r.bank = res[4:0];
                  OFF_ACC: next_r.acc = res;
                  OFF_PCLATH: next_r.pclath = res;
                  OFF_INTCON: next_r.intcon = res;
                  default: next_r.pcl = r.pcl;
               endcase
            end
            else if (addr[6:0] >= COMMON_FIRST)
            begin
               com_we = 1'b1;
            end
            else if (addr[6:0] >= GPR_FIRST)
            begin
               gpr_we = 1'b1;
            end
         end
      end
      // power flags move only on hardware events; expiry is applied last
      if (sleep_instr)
      begin
         next_r.wdt_expiry_n = 1'b1;
         next_r.sleep_entered_n = 1'b0;
      end
      if (watchdog_kick_instr)
      begin
         next_r.wdt_expiry_n = 1'b1;
         next_r.sleep_entered_n = 1'b1;
      end
      if (wdt_timeout)
      begin
         next_r.wdt_expiry_n = 1'b0;
      end
      // non power-on reset: abort and unbank, arithmetic flags survive
      if (other_reset)
      begin
         next_r.phase = PH_IDLE;
         next_r.bank = RST_BANK;
         next_r.done = 1'b0;
         next_r.pm_req = 1'b0;
         gpr_we = 1'b0;
         com_we = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r <= RESET_STATE;
      end
      else
      begin
         r <= next_r;
      end
   end

   // ram has no reset, its contents are undefined after power-up
   always_ff @(posedge clk)
   begin
      if (gpr_we)
      begin
         gpr_ram[gpr_idx] <= wr_data;
      end
      if (com_we)
      begin
         common_ram[com_idx] <= wr_data;
      end
   end

   assign busy = r.phase[1];
   assign done = r.done;
   assign result_data = r.result;
   assign arith_and_power_flags = {3'h0, r.wdt_expiry_n, r.sleep_entered_n, r.zero,
                                   r.nibble_overflow_flag, r.carry};
   assign working_accumulator = r.acc;
   assign bank_select = r.bank;
   assign pm_req = r.pm_req;
   assign pm_addr = r.pm_addr;

   pm_fetch_a: assert property (issue && to_pm && !other_reset |=> pm_req && busy)
      else $error("pointer bit 7 did not start a program memory fetch");

   pm_acc_a: assert property (finish && r.op == OP_READ && !other_reset
         |=> working_accumulator == $past(pm_rdata[7:0]))
      else $error("program memory low byte not loaded into accumulator");

   pm_no_write_a: assert property (finish |-> !gpr_we && !com_we)
      else $error("write reached memory during a program memory access");

   pm_latency_a: assert property (issue && to_pm && !other_reset
         |=> !done ##1 (done && !busy))
      else $error("program memory access did not take exactly one extra cycle");

   direct_latency_a: assert property (issue && !to_pm && !other_reset |=> done && !busy)
      else $error("direct access did not complete in one cycle");

   status_upper_a: assert property (arith_and_power_flags[7:5] == 3'h0)
      else $error("status upper bits not zero");

   power_flags_a: assert property (!sleep_instr && !watchdog_kick_instr && !wdt_timeout
         |=> $stable(arith_and_power_flags[ST_TO:ST_PD]))
      else $error("timeout or power-down flag changed without a hardware event");

   sleep_flags_a: assert property (sleep_instr && !watchdog_kick_instr && !wdt_timeout
         |=> arith_and_power_flags[ST_TO:ST_PD] == 2'b10)
      else $error("sleep did not leave timeout set and power-down cleared");

   expiry_a: assert property (wdt_timeout |=> !arith_and_power_flags[ST_TO])
      else $error("watchdog expiry did not clear the timeout flag");

   clr_status_a: assert property (exec && !finish && op == OP_CLR && status_target
         && !other_reset |=> arith_and_power_flags[ST_Z]
         && arith_and_power_flags[ST_DC:ST_C] == $past(arith_and_power_flags[ST_DC:ST_C]))
      else $error("clearing status did not set zero and keep the carries");

   add_flags_a: assert property (exec && op == OP_ADD && !other_reset
         |=> arith_and_power_flags[ST_C] == $past(sum9[8])
         && arith_and_power_flags[ST_Z] == ($past(sum9[7:0]) == 8'h00))
      else $error("add did not set carry and zero from its sum");

   pm_read_c: cover property (issue && to_pm && instr_op == OP_READ ##2 done);
   status_clr_c: cover property (exec && op == OP_CLR && status_target);
   sub_borrow_c: cover property (exec && op == OP_SUB && !sum9[8]);
   sleep_c: cover property (sleep_instr ##1 !arith_and_power_flags[ST_PD]);

endmodule : banked_data_memory_status

// [core/bdm_pkg.sv]
// constants, types and reset values for the banked data memory and status flags
package bdm_pkg;

   localparam int BANK_COUNT = 32;
   localparam int BANK_BYTES = 128;
   localparam int BANK_W = 5;
   localparam int OFFSET_W = 7;
   localparam int ADDR_W = 12;
   localparam int PM_ADDR_W = 15;
   localparam int PM_WORD_W = 14;
   localparam int GPR_BYTES = 80;
   localparam int COMMON_BYTES = 16;
   localparam int GPR_TOTAL = BANK_COUNT * GPR_BYTES;
   localparam int GPR_INDEX_W = 12;

   // core register offsets, identical in every bank
   localparam logic [6:0] OFF_PORT0 = 7'h00;
   localparam logic [6:0] OFF_PORT1 = 7'h01;
   localparam logic [6:0] OFF_PCL = 7'h02;
   localparam logic [6:0] OFF_STATUS = 7'h03;
   localparam logic [6:0] OFF_PTR0_LO = 7'h04;
   localparam logic [6:0] OFF_PTR0_HI = 7'h05;
   localparam logic [6:0] OFF_PTR1_LO = 7'h06;
   localparam logic [6:0] OFF_PTR1_HI = 7'h07;
   localparam logic [6:0] OFF_BANK = 7'h08;
   localparam logic [6:0] OFF_ACC = 7'h09;
   localparam logic [6:0] OFF_PCLATH = 7'h0a;
   localparam logic [6:0] OFF_INTCON = 7'h0b;
   localparam logic [6:0] CORE_COUNT = 7'h0c;
   localparam logic [6:0] GPR_FIRST = 7'h20;
   localparam logic [6:0] COMMON_FIRST = 7'h70;

   // status bit positions and the program memory select bit of the pointer high byte
   localparam int ST_TO = 4;
   localparam int ST_PD = 3;
   localparam int ST_Z = 2;
   localparam int ST_DC = 1;
   localparam int ST_C = 0;
   localparam int PM_SEL_BIT = 7;

   // reset values at power-on or brown-out
   localparam logic RST_TO_N = 1'b1;
   localparam logic RST_PD_N = 1'b1;
   localparam logic RST_ARITH = 1'b0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_BANK = 5'h00;

   // cycles from the taking edge to done
   localparam int DIRECT_CYCLES = 1;
   localparam int PM_EXTRA_CYCLES = 1;

   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_WRITE = 3'h1,
      OP_ADD = 3'h2,
      OP_SUB = 3'h3,
      OP_AND = 3'h4,
      OP_RRF = 3'h5,
      OP_RLF = 3'h6,
      OP_CLR = 3'h7
   } op_type;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b01,
      PH_PM = 2'b10
   } phase_type;

   typedef struct packed {
      phase_type phase;
      op_type op;
      logic [7:0] operand;
      logic [4:0] bank;
      logic [1:0][7:0] pointer_low;
      logic [1:0][7:0] pointer_high_byte;
      logic [7:0] acc;
      logic [7:0] pcl;
      logic [7:0] pclath;
      logic [7:0] intcon;
      logic wdt_expiry_n;
      logic sleep_entered_n;
      logic zero;
      logic nibble_overflow_flag;
      logic carry;
      logic [7:0] result;
      logic done;
      logic pm_req;
      logic [14:0] pm_addr;
   } state_type;

   localparam state_type RESET_STATE = '{
      phase: PH_IDLE,
      op: OP_READ,
      bank: RST_BANK,
      wdt_expiry_n: RST_TO_N,
      sleep_entered_n: RST_PD_N,
      zero: RST_ARITH,
      nibble_overflow_flag: RST_ARITH,
      carry: RST_ARITH,
      default: '0
   };

endpackage : bdm_pkg

// [dv/pm_model.sv]
// program memory model answering fetches from the indirect pointer path
module pm_model
#(
   parameter logic [13:0] KEY = 14'h2c5a
)
(
   input wire logic clk,
   input wire logic pm_req,
   input wire logic [14:0] pm_addr,
   output logic [13:0] pm_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] last = 14'h0000;
   // outside a fetch the bus keeps flipping, so stale data is never a match by chance
   always @(posedge clk)
   begin
      last <= ~pm_rdata;
   end
   always_comb
   begin
      if (pm_req)
         pm_rdata = pm_addr[13:0] ^ KEY;
      else
         pm_rdata = last;
   end
endmodule : pm_model

// [dv/tb_top.sv]
// self-checking bench for the banked data memory and status flags
module tb_top
   import bdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [13:0] PM_KEY = 14'h1b36;
   logic clk = 1'b0;
   logic resetn, other_reset, instr_valid, wdt_timeout, watchdog_kick_instr, sleep_instr;
   op_type instr_op;
   logic [6:0] instr_offset;
   logic [7:0] instr_operand, result_data, arith_and_power_flags, working_accumulator;
   logic [13:0] pm_rdata;
   logic busy, done, pm_req;
   logic [4:0] bank_select;
   logic [14:0] pm_addr;
   logic [13:0] w;
   logic [1:0] seen;
   int fail_count, checked, cyc;
   op_type ops [7] = '{OP_ADD, OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB};
   logic [7:0] tv [7] = '{8'h0f, 8'hff, 8'h12, 8'h00, 8'h05, 8'h10, 8'h00};
   logic [7:0] xv [7] = '{8'h01, 8'h01, 8'h34, 8'h00, 8'h05, 8'h01, 8'h01};
   logic [2:0] evs [5] = '{3'h1, 3'h2, 3'h4, 3'h1, 3'h5};
   logic [1:0] evx [5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h0};

   always #5 clk = ~clk;

   banked_data_memory_status banked_data_memory_status_i (.clk, .resetn, .other_reset,
      .instr_valid, .instr_op, .instr_offset, .instr_operand, .pm_rdata, .wdt_timeout,
      .watchdog_kick_instr, .sleep_instr, .busy, .done, .result_data, .arith_and_power_flags,
      .working_accumulator, .bank_select, .pm_req, .pm_addr);
   pm_model #(.KEY(PM_KEY)) pm_model_i (.clk, .pm_req, .pm_addr, .pm_rdata);

   task automatic results();
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one instruction; cyc ends as the cycles beyond the single direct cycle
   task automatic run(input op_type o, input logic [6:0] off, input logic [7:0] d);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr_op <= o;
      instr_offset <= off;
      instr_operand <= d;
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      seen = {busy, pm_req};
      cyc = 0;
      while (done !== 1'b1)
      begin
         if (cyc == 8)
         begin
            fail_count++;
            $display("ERROR at %0t: no completion", $time);
            results();
         end
         @(posedge clk);
         #1;
         cyc++;
      end
   endtask : run

   task automatic arith(input op_type o, input logic [6:0] off, input logic [7:0] t,
      input logic [7:0] x);
      logic [7:0] y;
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] f;
      y = (o == OP_SUB) ? ~x : x;
      s = {1'b0, t} + {1'b0, y} + {8'h00, o == OP_SUB};
      h = {1'b0, t[3:0]} + {1'b0, y[3:0]} + {4'h0, o == OP_SUB};
      f = arith_and_power_flags;
      run(o, off, x);
      chk(arith_and_power_flags, {f[7:3], s[7:0] == 8'h00, h[4], s[8]});
      if (off != OFF_STATUS)
         chk(result_data, s[7:0]);
   endtask : arith

   task automatic pulse(input logic [2:0] ev);
      @(posedge clk);
      {wdt_timeout, watchdog_kick_instr, sleep_instr} <= ev;
      @(posedge clk);
      {wdt_timeout, watchdog_kick_instr, sleep_instr} <= 3'h0;
      #1;
   endtask : pulse

   initial
   begin
      resetn = 1'b0;
      other_reset = 1'b0;
      instr_valid = 1'b0;
      instr_op = OP_READ;
      instr_offset = 7'h00;
      instr_operand = 8'h00;
      {wdt_timeout, watchdog_kick_instr, sleep_instr} = 3'h0;
      fail_count = 0;
      checked = 0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk(arith_and_power_flags, 8'h18);
      chk(bank_select, 5'h00);
      run(OP_WRITE, OFF_BANK, 8'h05);
      chk(bank_select, 5'h05);
      run(OP_WRITE, 7'h20, 8'ha5);
      run(OP_WRITE, 7'h70, 8'h5c);
      run(OP_WRITE, OFF_BANK, 8'h1f);
      run(OP_WRITE, 7'h20, 8'h3c);
      run(OP_READ, 7'h70, 8'h00);
      chk(working_accumulator, 8'h5c);
      run(OP_READ, OFF_BANK, 8'h00);
      chk(working_accumulator, 8'h1f);
      run(OP_WRITE, OFF_BANK, 8'h05);
      run(OP_READ, 7'h20, 8'h00);
      chk(working_accumulator, 8'ha5);
      run(OP_WRITE, 7'h0c, 8'hff);
      run(OP_READ, 7'h0c, 8'h00);
      chk(working_accumulator, 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         run(OP_WRITE, 7'h21, tv[i]);
         arith(ops[i], 7'h21, tv[i], xv[i]);
      end
      run(OP_WRITE, 7'h22, 8'hf0);
      run(OP_AND, 7'h22, 8'h0f);
      chk(arith_and_power_flags[2], 1'b1);
      run(OP_WRITE, OFF_STATUS, 8'h01);
      run(OP_WRITE, 7'h22, 8'h02);
      run(OP_RRF, 7'h22, 8'h00);
      chk({result_data, arith_and_power_flags[0]}, {8'h81, 1'b0});
      run(OP_RLF, 7'h22, 8'h00);
      chk({result_data, arith_and_power_flags[0]}, {8'h02, 1'b1});
      run(OP_WRITE, OFF_STATUS, 8'hff);
      chk(arith_and_power_flags, 8'h1f);
      run(OP_WRITE, OFF_STATUS, 8'h03);
      run(OP_CLR, OFF_STATUS, 8'h00);
      chk(arith_and_power_flags, 8'h1f);
      run(OP_WRITE, OFF_STATUS, 8'h00);
      arith(OP_ADD, OFF_STATUS, 8'h18, 8'he8);
      for (int i = 0; i < 5; i++)
      begin
         pulse(evs[i]);
         chk(arith_and_power_flags[4:3], evx[i]);
      end
      run(OP_WRITE, OFF_STATUS, 8'hff);
      chk(arith_and_power_flags, 8'h07);
      @(posedge clk);
      other_reset <= 1'b1;
      @(posedge clk);
      other_reset <= 1'b0;
      #1;
      chk({arith_and_power_flags, 3'h0, bank_select}, 16'h0700);
      run(OP_WRITE, OFF_PTR0_HI, 8'h81);
      run(OP_WRITE, OFF_PTR0_LO, 8'h23);
      run(OP_READ, 7'h00, 8'h00);
      w = 14'h0123 ^ PM_KEY;
      chk(16'(cyc), 16'h0001);
      chk(seen, 2'b11);
      chk(pm_addr, 15'h0123);
      chk(working_accumulator, w[7:0]);
      run(OP_WRITE, OFF_PTR1_HI, 8'hbf);
      run(OP_WRITE, OFF_PTR1_LO, 8'hff);
      run(OP_READ, 7'h01, 8'h00);
      w = 14'h3fff ^ PM_KEY;
      chk({pm_addr, 1'b0}, {15'h3fff, 1'b0});
      chk(working_accumulator, w[7:0]);
      run(OP_WRITE, 7'h01, 8'h00);
      chk(16'(cyc), 16'h0001);
      run(OP_READ, 7'h01, 8'h00);
      chk(working_accumulator, w[7:0]);
      run(OP_WRITE, OFF_PTR0_HI, 8'h02);
      run(OP_WRITE, OFF_PTR0_LO, 8'ha0);
      run(OP_READ, 7'h00, 8'h00);
      chk({16'(cyc), working_accumulator}, {16'h0000, 8'ha5});
      chk(seen, 2'b00);
      run(OP_WRITE, 7'h00, 8'h6e);
      run(OP_WRITE, OFF_BANK, 8'h05);
      run(OP_READ, 7'h20, 8'h00);
      chk(working_accumulator, 8'h6e);
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk(arith_and_power_flags, 8'h18);
      results();
   end
endmodule : tb_top
